//--- verilog/dpo_port.sv
// Purpose: Parallel output port of a wideband downconverter, one port
// Assumes: Stage samples and controls on CLK_IN; port clock and ack are pins
// Notes:   Slave port clock rising edges and master divider wraps become one-cycle ticks of CLK_IN
`timescale 1ns/100ps
module dpo_port (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        MASTER_MODE_IN,
  input  wire logic [1:0]  PCLK_DIV_IN,
  input  wire logic        DATA_FORMAT_IN,
  input  wire logic        APPEND_GAIN_IN,
  input  wire logic [5:0]  STAGE_EN_IN,
  input  wire logic [5:0]  STAGE_VALID_IN,
  output logic      [5:0]  STAGE_READY_OUT,
  input  wire logic [95:0] STAGE_I_IN,
  input  wire logic [95:0] STAGE_Q_IN,
  input  wire logic [95:0] STAGE_GAIN_IN,
  input  wire logic        PCLK_IN,
  output logic             PCLK_OUT,
  output logic             PCLK_OE_OUT,
  input  wire logic        RECEIVER_ACKNOWLEDGE_IN,
  output logic             DATA_REQUEST_OUT,
  output logic             INPHASE_INDICATOR_OUT,
  output logic             GAIN_WORD_INDICATOR_OUT,
  output logic      [2:0]  SOURCE_CHANNEL_ID_OUT,
  output logic      [15:0] OUTPUT_PORT_BUS_OUT
);
  localparam int NS = dpo_pkg::NUM_STAGES;
  localparam int SW = dpo_pkg::SAMPLE_W;
  localparam int EW = dpo_pkg::ENTRY_W;

  // ----------------------------------------------------------------
  // Port clock
  // ----------------------------------------------------------------
  logic [dpo_pkg::DIV_CNT_W-1:0] div_cnt_ff;
  logic [dpo_pkg::DIV_CNT_W-1:0] div_len;
  logic [dpo_pkg::DIV_CNT_W-1:0] nxt_div_cnt;
  logic                          pclk_out_ff;
  logic                          oe_ff;
  logic                          pclk_s1_ff;
  logic                          pclk_s2_ff;
  logic                          pclk_s3_ff;
  logic                          tick;
  assign div_len     = dpo_pkg::DIV_CNT_W'(1) << PCLK_DIV_IN;
  assign nxt_div_cnt = (div_cnt_ff >= div_len - 1'b1) ? '0 : div_cnt_ff + 1'b1;
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      div_cnt_ff  <= '0;
      pclk_out_ff <= 1'b1;
    end else begin
      div_cnt_ff  <= nxt_div_cnt;
      // Rising edge of the pin coincides with the counter wrap
      pclk_out_ff <= (div_len == dpo_pkg::DIV_CNT_W'(1)) |
                     (nxt_div_cnt < (div_len >> 1));
    end
  end

  // Pin stays an input until master mode is chosen
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= MASTER_MODE_IN;
    end
  end

  // Slave clock may be asynchronous, so synchronise it first
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      pclk_s1_ff <= 1'b0;
      pclk_s2_ff <= 1'b0;
      pclk_s3_ff <= 1'b0;
    end else begin
      pclk_s1_ff <= PCLK_IN;
      pclk_s2_ff <= pclk_s1_ff;
      pclk_s3_ff <= pclk_s2_ff;
    end
  end

  // Tick source follows the mode bit
  assign tick = MASTER_MODE_IN ? (nxt_div_cnt == '0) : (pclk_s2_ff & ~pclk_s3_ff);
  assign PCLK_OUT    = pclk_out_ff;
  assign PCLK_OE_OUT = oe_ff;

  // ----------------------------------------------------------------
  // Acknowledge synchroniser
  // ----------------------------------------------------------------
  logic ack_s1_ff;
  logic ack_s2_ff;
  // Two flops before any logic reads acknowledge
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      ack_s1_ff <= RECEIVER_ACKNOWLEDGE_IN;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Stage capture and arbitration
  // ----------------------------------------------------------------
  logic [NS-1:0]   pend_ff;
  logic [EW-1:0]   slot_ff [NS];
  logic [NS-1:0]   grant;
  logic            any_pend;
  logic            fifo_in_ready;
  logic            fifo_push;
  logic [EW-1:0]   push_data;
  function automatic logic [NS-1:0] dpo_first_one(input logic [NS-1:0] req);
    logic [NS-1:0] g;
    g = '0;
    for (int k = NS - 1; k >= 0; k--) begin
      if (req[k]) begin
        g = '0;
        g[k] = 1'b1;
      end
    end
    return g;
  endfunction : dpo_first_one
  assign grant     = dpo_first_one(pend_ff);
  assign any_pend  = |pend_ff;
  assign fifo_push = any_pend;
  always_comb begin
    push_data = '0;
    for (int k = 0; k < NS; k++) begin
      if (grant[k]) begin
        push_data = slot_ff[k];
      end
    end
  end

  genvar gs;
  generate
    for (gs = 0; gs < NS; gs++) begin : g_stage
      // Disabled stages are drained and dropped
      assign STAGE_READY_OUT[gs] = ~pend_ff[gs] | ~STAGE_EN_IN[gs];

      always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
          pend_ff[gs] <= 1'b0;
          slot_ff[gs] <= '0;
        end else if (!STAGE_EN_IN[gs]) begin
          pend_ff[gs] <= 1'b0;
        end else if (STAGE_VALID_IN[gs] & ~pend_ff[gs]) begin
          pend_ff[gs] <= 1'b1;
          slot_ff[gs] <= {dpo_pkg::CHAN_W'(gs),
                          STAGE_I_IN[gs*SW +: SW],
                          STAGE_Q_IN[gs*SW +: SW],
                          STAGE_GAIN_IN[gs*SW +: SW]};
        end else if (grant[gs] & fifo_in_ready) begin
          pend_ff[gs] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sample FIFO
  // ----------------------------------------------------------------
  logic          fifo_out_valid;
  logic          fifo_pop;
  logic [EW-1:0] fifo_out_data;
  dpo_fifo #(
    .WIDTH (EW),
    .DEPTH (dpo_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CLK_IN),
    .rst_n_in      (RST_N_IN),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (push_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Port shifter
  // ----------------------------------------------------------------
  dpo_pkg::dpo_state_t state_ff;
  dpo_pkg::dpo_state_t nxt_state;
  logic [EW-1:0]       cur_ff;
  logic [EW-1:0]       nxt_cur;
  logic                req_ff;
  logic                nxt_req;
  logic                iq_ff;
  logic                nxt_iq;
  logic                gain_ff;
  logic                nxt_gain;
  logic [2:0]          chan_ff;
  logic [2:0]          nxt_chan;
  logic [15:0]         bus_ff;
  logic [15:0]         nxt_bus;
  logic                last_word;
  // Leaving the last word of a sample
  always_comb begin
    unique case (state_ff)
      dpo_pkg::ST_FIRST: last_word = (DATA_FORMAT_IN == dpo_pkg::FMT_PARALLEL) &
                                     ~APPEND_GAIN_IN;
      dpo_pkg::ST_QUAD:  last_word = ~APPEND_GAIN_IN;
      dpo_pkg::ST_GAIN:  last_word = 1'b1;
      default:           last_word = 1'b0;
    endcase
  end
  always_comb begin
    nxt_state = state_ff;
    nxt_cur   = cur_ff;
    nxt_req   = req_ff;
    nxt_iq    = iq_ff;
    nxt_gain  = gain_ff;
    nxt_chan  = chan_ff;
    nxt_bus   = bus_ff;
    fifo_pop  = 1'b0;
    // Everything moves on a port clock tick only
    if (tick) begin
      unique case (state_ff)
        dpo_pkg::ST_IDLE: begin
          // Raise request once a sample is queued
          if (fifo_out_valid) begin
            fifo_pop  = 1'b1;
            nxt_cur   = fifo_out_data;
            nxt_req   = 1'b1;
            nxt_state = dpo_pkg::ST_REQ;
          end
        end
        default: begin
          // Acknowledge low holds the bus as it is
          // Sampled ack releases the next word
          if (ack_s2_ff) begin
            nxt_iq   = 1'b0;
            nxt_gain = 1'b0;
            // First word on the tick after request
            if (state_ff == dpo_pkg::ST_REQ) begin
              nxt_state = dpo_pkg::ST_FIRST;
            end else if (last_word) begin
              if (fifo_out_valid) begin
                fifo_pop  = 1'b1;
                nxt_cur   = fifo_out_data;
                nxt_state = dpo_pkg::ST_FIRST;
              end else begin
                // Request drops when nothing is left
                nxt_req   = 1'b0;
                nxt_state = dpo_pkg::ST_IDLE;
              end
            end else if (state_ff == dpo_pkg::ST_FIRST &&
                         DATA_FORMAT_IN == dpo_pkg::FMT_INTERLEAVED) begin
              nxt_state = dpo_pkg::ST_QUAD;
            end else begin
              nxt_state = dpo_pkg::ST_GAIN;
            end
            // Source id follows the sample on the bus
            nxt_chan = nxt_cur[dpo_pkg::CHAN_LSB +: dpo_pkg::CHAN_W];
            unique case (nxt_state)
              dpo_pkg::ST_FIRST: begin
                nxt_iq = 1'b1;
                // I byte high, Q byte low
                if (DATA_FORMAT_IN == dpo_pkg::FMT_PARALLEL) begin
                  nxt_bus = {nxt_cur[dpo_pkg::I_LSB + dpo_pkg::BYTE_HI_LSB +: dpo_pkg::BYTE_W],
                             nxt_cur[dpo_pkg::Q_LSB + dpo_pkg::BYTE_HI_LSB +: dpo_pkg::BYTE_W]};
                end else begin
                  nxt_bus = nxt_cur[dpo_pkg::I_LSB +: SW];
                end
              end
              // Q follows I in interleaved mode
              dpo_pkg::ST_QUAD: nxt_bus = nxt_cur[dpo_pkg::Q_LSB +: SW];
              dpo_pkg::ST_GAIN: begin
                nxt_gain = 1'b1;
                nxt_bus  = nxt_cur[dpo_pkg::GAIN_LSB +: SW];
              end
              default: begin
                nxt_bus  = dpo_pkg::BUS_IDLE;
                nxt_chan = dpo_pkg::CHAN_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      state_ff <= dpo_pkg::ST_IDLE;
      cur_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cur_ff   <= nxt_cur;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      req_ff  <= 1'b0;
      iq_ff   <= 1'b0;
      gain_ff <= 1'b0;
      chan_ff <= dpo_pkg::CHAN_IDLE;
      bus_ff  <= dpo_pkg::BUS_IDLE;
    end else begin
      req_ff  <= nxt_req;
      iq_ff   <= nxt_iq;
      gain_ff <= nxt_gain;
      chan_ff <= nxt_chan;
      bus_ff  <= nxt_bus;
    end
  end

  assign DATA_REQUEST_OUT        = req_ff;
  assign INPHASE_INDICATOR_OUT   = iq_ff;
  assign GAIN_WORD_INDICATOR_OUT = gain_ff;
  assign SOURCE_CHANNEL_ID_OUT   = chan_ff;
  assign OUTPUT_PORT_BUS_OUT     = bus_ff;
endmodule : dpo_port

//--- verilog/dpo_pkg.sv
// Purpose: Shared constants for the downconverter parallel output port
// Assumes: One port instance; all constants at their documented values
// Notes:   Entry layout is channel id, in-phase, quadrature, gain word
package dpo_pkg;
  localparam int          NUM_STAGES   = 6;
  localparam int          SAMPLE_W     = 16;
  localparam int          CHAN_W       = 3;
  localparam int          DIV_SEL_W    = 2;
  localparam int          DIV_CNT_W    = 4;
  localparam int          FIFO_DEPTH   = 32;
  // Entry field positions
  localparam int          GAIN_LSB     = 0;
  localparam int          Q_LSB        = 16;
  localparam int          I_LSB        = 32;
  localparam int          CHAN_LSB     = 48;
  localparam int          ENTRY_W      = 51;
  // Parallel I/Q mode keeps the upper byte of each half
  localparam int          BYTE_W       = 8;
  localparam int          BYTE_HI_LSB  = 8;
  localparam logic        FMT_INTERLEAVED = 1'b0;
  localparam logic        FMT_PARALLEL    = 1'b1;
  localparam logic [15:0] BUS_IDLE     = 16'h0000;
  localparam logic [2:0]  CHAN_IDLE    = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_REQ   = 3'b001,
    ST_FIRST = 3'b010,
    ST_QUAD  = 3'b011,
    ST_GAIN  = 3'b100
  } dpo_state_t;
endpackage : dpo_pkg

//--- verilog/dpo_fifo.sv
// Purpose: Sample FIFO between stage arbiter and port shifter
// Assumes: Single clock, synchronous active-low reset
// Notes:   Read data come from an output register; capacity DEPTH plus one
`timescale 1ns/100ps
module dpo_fifo #(
  parameter int WIDTH = 51,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic             out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             push;
  logic             load;

  assign in_ready_out  = (cnt_ff < (AW+1)'(DEPTH));
  assign push          = in_valid_in & in_ready_out;
  assign load          = (cnt_ff != '0) & (~out_valid_ff | out_ready_in);
  assign out_valid_out = out_valid_ff;
  assign out_data_out  = out_data_ff;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (load) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (load) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= mem[rd_ptr_ff];
    end else if (out_ready_in) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule : dpo_fifo

//--- verif/dpo_port_props.sv
// Purpose: Timing and framing checks on the output port pins
// Assumes: Configuration ports held steady between resets
// Notes:   Bound to every dpo_port instance
`timescale 1ns/100ps
module dpo_port_props (
  input wire logic        CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        MASTER_MODE_IN,
  input wire logic [1:0]  PCLK_DIV_IN,
  input wire logic        DATA_FORMAT_IN,
  input wire logic        APPEND_GAIN_IN,
  input wire logic        PCLK_OUT,
  input wire logic        PCLK_OE_OUT,
  input wire logic        RECEIVER_ACKNOWLEDGE_IN,
  input wire logic        DATA_REQUEST_OUT,
  input wire logic        INPHASE_INDICATOR_OUT,
  input wire logic        GAIN_WORD_INDICATOR_OUT,
  input wire logic [2:0]  SOURCE_CHANNEL_ID_OUT,
  input wire logic [15:0] OUTPUT_PORT_BUS_OUT
);
  logic [21:0] port_vec;
  assign port_vec = {DATA_REQUEST_OUT, INPHASE_INDICATOR_OUT, GAIN_WORD_INDICATOR_OUT,
                     SOURCE_CHANNEL_ID_OUT, OUTPUT_PORT_BUS_OUT};
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence div8_master;
    MASTER_MODE_IN && PCLK_DIV_IN == 2'h3;
  endsequence
  sequence pclk_rise;
    $rose(PCLK_OUT);
  endsequence
  sequence req_with_ack;
    RECEIVER_ACKNOWLEDGE_IN [*3] ##0 $rose(DATA_REQUEST_OUT);
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  pclk_hiz_a: assert property (!MASTER_MODE_IN |=> !PCLK_OE_OUT)
    else $error("port clock driven in slave mode");
  pclk_drive_a: assert property (MASTER_MODE_IN [*2] |-> PCLK_OE_OUT)
    else $error("port clock not driven in master mode");
  div_eight_a: assert property (div8_master ##0 pclk_rise |=>
    (!$rose(PCLK_OUT)) [*7] ##1 pclk_rise) else $error("port clock period wrong");
  tick_only_a: assert property (div8_master ##0 $changed(port_vec) |=>
    $stable(port_vec) [*7]) else $error("output changed between ticks");
  idle_quiet_a: assert property (!DATA_REQUEST_OUT |-> port_vec == 22'h0)
    else $error("port outputs busy without request");
  ack_stall_a: assert property (!RECEIVER_ACKNOWLEDGE_IN [*5] |=> $stable(port_vec[20:0]))
    else $error("word moved while acknowledge low");
  first_word_a: assert property (div8_master ##0 req_with_ack ##1
    RECEIVER_ACKNOWLEDGE_IN [*5] |-> ##3 INPHASE_INDICATOR_OUT)
    else $error("first word late");
  iq_then_q_a: assert property (DATA_FORMAT_IN == dpo_pkg::FMT_INTERLEAVED &&
    $past(INPHASE_INDICATOR_OUT) && $changed(OUTPUT_PORT_BUS_OUT) |->
    !INPHASE_INDICATOR_OUT && !GAIN_WORD_INDICATOR_OUT) else $error("no Q after I");
  gain_excl_a: assert property (GAIN_WORD_INDICATOR_OUT |->
    !INPHASE_INDICATOR_OUT && APPEND_GAIN_IN) else $error("stray gain indicator");
  par_iq_a: assert property (DATA_FORMAT_IN == dpo_pkg::FMT_PARALLEL &&
    DATA_REQUEST_OUT && $changed(OUTPUT_PORT_BUS_OUT) && !GAIN_WORD_INDICATOR_OUT
    |-> INPHASE_INDICATOR_OUT) else $error("parallel word without I flag");
endmodule : dpo_port_props

bind dpo_port dpo_port_props props_u (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .MASTER_MODE_IN(MASTER_MODE_IN), .PCLK_DIV_IN(PCLK_DIV_IN), .DATA_FORMAT_IN(DATA_FORMAT_IN),
  .APPEND_GAIN_IN(APPEND_GAIN_IN), .PCLK_OUT(PCLK_OUT), .PCLK_OE_OUT(PCLK_OE_OUT),
  .RECEIVER_ACKNOWLEDGE_IN(RECEIVER_ACKNOWLEDGE_IN), .DATA_REQUEST_OUT(DATA_REQUEST_OUT),
  .INPHASE_INDICATOR_OUT(INPHASE_INDICATOR_OUT),
  .GAIN_WORD_INDICATOR_OUT(GAIN_WORD_INDICATOR_OUT),
  .SOURCE_CHANNEL_ID_OUT(SOURCE_CHANNEL_ID_OUT), .OUTPUT_PORT_BUS_OUT(OUTPUT_PORT_BUS_OUT));

//--- verif/dpo_rx_model.sv
// Purpose: Receiving processor at the far side of the output port
// Assumes: Acknowledge style chosen by the bench per scenario
// Notes:   Slave clock phase unrelated to the core clock
`timescale 1ns/100ps
module dpo_rx_model #(
  parameter real HALF_NS = 21.0
) (
  input  wire logic       run_in,
  input  wire logic [1:0] ack_mode_in,
  input  wire logic       pclk_wire_in,
  output logic            pclk_out,
  output logic            ack_out
);
  logic slow_ff;
  initial pclk_out = 1'b0;
  always begin
    #(HALF_NS);
    pclk_out = run_in ? ~pclk_out : 1'b0;
  end
  initial slow_ff = 1'b0;
  always @(negedge pclk_wire_in) slow_ff <= ~slow_ff;
  assign ack_out = (ack_mode_in == 2'h0) || (ack_mode_in == 2'h2 && slow_ff);
endmodule : dpo_rx_model

//--- verif/dpo_port_tb_top.sv
// Purpose: Self-checking bench for the downconverter output port
// Assumes: Receiver model gives acknowledge and the slave port clock
// Notes:   Each scenario resets first so the divider starts clean
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module dpo_port_tb_top;
  logic        clk, rst_n, master, fmt, app, run, slave_clk, ack, pclk_wire;
  logic        pclk_o, oe, req, iq, gw;
  logic [1:0]  div, ack_mode;
  logic [2:0]  ch;
  logic [5:0]  en, valid, ready;
  logic [15:0] bus;
  logic [20:0] prev_w;
  logic [20:0] seen_q[$];
  logic [20:0] exp_q[$];
  logic [95:0] si, sq, sg;
  int          bad_count, n_compared;

  initial clk = 1'b0;
  always #4 clk = ~clk;
  assign pclk_wire = oe ? pclk_o : slave_clk;

  dpo_port dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .MASTER_MODE_IN(master), .PCLK_DIV_IN(div),
    .DATA_FORMAT_IN(fmt), .APPEND_GAIN_IN(app), .STAGE_EN_IN(en), .STAGE_VALID_IN(valid),
    .STAGE_READY_OUT(ready), .STAGE_I_IN(si), .STAGE_Q_IN(sq), .STAGE_GAIN_IN(sg),
    .PCLK_IN(pclk_wire), .PCLK_OUT(pclk_o), .PCLK_OE_OUT(oe), .RECEIVER_ACKNOWLEDGE_IN(ack),
    .DATA_REQUEST_OUT(req), .INPHASE_INDICATOR_OUT(iq), .GAIN_WORD_INDICATOR_OUT(gw),
    .SOURCE_CHANNEL_ID_OUT(ch), .OUTPUT_PORT_BUS_OUT(bus));
  dpo_rx_model rx_u (.run_in(run), .ack_mode_in(ack_mode), .pclk_wire_in(pclk_wire),
    .pclk_out(slave_clk), .ack_out(ack));

  // ----------------------------------------
  // Word capture and helpers
  // ----------------------------------------
  always @(posedge clk) begin
    prev_w <= {iq, gw, ch, bus};
    if ({iq, gw, ch, bus} !== prev_w && {iq, gw, ch, bus} !== 21'h0) begin
      seen_q.push_back({iq, gw, ch, bus});
    end
  end

  task automatic start(input logic m, input logic [1:0] d, input logic f, input logic a,
                       input logic [1:0] am);
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    {master, div, fmt, app, ack_mode, run, en} = {m, d, f, a, am, ~m, 6'h3f};
    repeat (3) @(posedge clk);
    #1;
    `CHK({oe, pclk_o, req, ready}, {1'b0, 1'b1, 1'b0, 6'h3f})
    rst_n = 1'b1;
    seen_q.delete();
    exp_q.delete();
  endtask : start

  task automatic offer(input logic [5:0] mask);
    `CHK(ready & mask, mask)
    valid = mask;
    @(posedge clk);
    #1 valid = 6'h0;
  endtask : offer

  task automatic add(input int k);
    logic [15:0] i, q;
    i = si[16*k+:16];
    q = sq[16*k+:16];
    if (fmt) begin
      exp_q.push_back({2'b10, 3'(k), i[15:8], q[15:8]});
    end else begin
      exp_q.push_back({2'b10, 3'(k), i});
      exp_q.push_back({2'b00, 3'(k), q});
    end
    if (app) exp_q.push_back({2'b01, 3'(k), sg[16*k+:16]});
  endtask : add

  task automatic expect_words(input int limit);
    int n;
    n = 0;
    while ((seen_q.size() < exp_q.size() || req !== 1'b0) && n < limit) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(seen_q.size(), exp_q.size())
    `CHK(req, 1'b0)
    foreach (exp_q[j]) begin
      if (j < seen_q.size()) `CHK(seen_q[j], exp_q[j])
    end
  endtask : expect_words

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_priority;
    start(1'b1, 2'h3, dpo_pkg::FMT_INTERLEAVED, 1'b1, 2'h0);
    en = 6'b111101;
    offer(6'b000111);
    add(0);
    add(2);
    expect_words(600);
    $display("priority test done");
  endtask : s_priority

  task automatic s_parallel;
    start(1'b0, 2'h0, dpo_pkg::FMT_PARALLEL, 1'b1, 2'h2);
    offer(6'b101000);
    add(3);
    add(5);
    expect_words(2000);
    `CHK(oe, 1'b0)
    $display("parallel slave test done");
  endtask : s_parallel

  task automatic s_divide_stall;
    int   rises;
    logic last;
    for (int d = 0; d < 4; d++) begin
      start(1'b1, 2'(d), d[0], 1'b0, 2'h1);
      offer(6'b010000);
      add(4);
      rises = 0;
      last = pclk_o;
      repeat (64) begin
        @(posedge clk);
        #1 rises += int'(pclk_o & ~last);
        last = pclk_o;
      end
      `CHK(rises, (d == 0) ? 0 : (64 >> d))
      `CHK({oe, req, bus}, {1'b1, 1'b1, 16'h0})
      ack_mode = 2'h0;
      expect_words(300);
    end
    $display("divider stall test done");
  endtask : s_divide_stall

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    {rst_n, master, fmt, app, run, valid, div, ack_mode, en} = '0;
    bad_count = 0;
    n_compared = 0;
    for (int k = 0; k < 6; k++) begin
      si[16*k+:16] = {8'h90 + 8'(k), 8'h5a};
      sq[16*k+:16] = {8'h40 + 8'(k), 8'h3c};
      sg[16*k+:16] = {8'h20 + 8'(k), 8'h11};
    end
    s_priority();
    s_parallel();
    s_divide_stall();
    complete_run();
  end

  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule : dpo_port_tb_top
